// file: test/motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module motor_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Supervisor commands
	input wire logic runEnable,
	input wire logic coastStop,
	input wire logic freqOverride,
	input wire logic [15:0] overrideFreq,
	// Operator demand
	input wire logic [15:0] demandFreq,
	// Measured frequency
	output logic [15:0] outFreq
);
	logic [15:0] goal;
	// Coasting winds down slowly, never jumps, so crossings are seen
	always_comb begin
		goal = 16'h0000;
		if (runEnable && !coastStop)
			goal = freqOverride ? overrideFreq : demandFreq;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			outFreq <= 16'h0000;
		else if (outFreq + 16'h000A < goal)
			outFreq <= outFreq + 16'h000A;
		else if (outFreq > goal + 16'h000A)
			outFreq <= outFreq - 16'h000A;
		else
			outFreq <= goal;
	end
endmodule // motor_model
`default_nettype wire

// file: test/supervisor_chk.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// Drive side
	input wire logic runEnable,
	input wire logic coastStop,
	input wire logic freqOverride,
	input wire logic breakSignalOut,
	input wire logic faultOut,
	input wire logic brakeOut,
	input wire logic traverseFault,
	input wire logic [7:0] faultCode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence setupPhase;
		psel && !penable;
	endsequence
	sequence oneWait;
		psel && penable && !pready ##1 pready;
	endsequence
	a_bus_one_wait: assert property (setupPhase |=> oneWait)
		else $error("bus answer not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_break_faults: assert property (breakSignalOut |-> faultOut)
		else $error("break signal without fault");
	a_override_on_break: assert property (freqOverride |-> breakSignalOut)
		else $error("override without break");
	a_brake_coasts: assert property (brakeOut ##1 brakeOut |-> coastStop)
		else $error("brake without coast");
	a_brake_no_run: assert property (brakeOut |-> !$rose(runEnable))
		else $error("run accepted during brake");
	a_traverse_code: assert property (traverseFault |-> faultCode == 8'h2C)
		else $error("traverse fault code wrong");
	a_traverse_coast: assert property (traverseFault |-> ##[0:1] coastStop)
		else $error("traverse fault without coast");
endmodule // supervisor_chk
bind wire_break_brake_traverse_supervisor supervisor_chk u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .prdata(prdata),
	.runEnable(runEnable), .coastStop(coastStop),
	.freqOverride(freqOverride), .breakSignalOut(breakSignalOut),
	.faultOut(faultOut), .brakeOut(brakeOut),
	.traverseFault(traverseFault), .faultCode(faultCode));
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wire_break_map.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 3000) begin \
	@(posedge ref_clk); k++; end if (k >= 3000) begin failures++; \
	summarize(); end end
module tb_top;
	logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, runCmdPin = 1'b0, proxBreakPin = 1'b0;
	logic traverseSensePin = 1'b0, faultResetPin = 1'b0, er;
	logic brakeResetPin = 1'b0, internalBreak = 1'b0;
	logic overrideReverse, reverseLimitOn;
	logic [15:0] reverseLimitFreq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] outFreq, demandFreq = 16'h0000;
	logic signed [15:0] feedforwardGain = 16'shEC78;
	logic pready, pslverr, runEnable, coastStop, freqOverride, brakeOut;
	logic breakSignalOut, faultOut, traverseFault;
	logic [15:0] overrideFreq;
	logic [7:0] faultCode;
	int failures = 0, tests_run = 0, k;
	logic [15:0] dflt [11] = '{{6'h00, `CTRL_RST}, `DELAY_RST, `FLOOR_RST,
		`CRTIME_RST, `CRFREQ_RST, `BRFREQ_RST, `BRHOLD_RST, `TRMIN_RST,
		`TRINACT_RST, `TRACT_RST, `FILTER_RST};
	logic [31:0] brk [3] = '{32'h090, 32'h080, 32'h010};
	always #20 ref_clk = ~ref_clk;
	wire_break_brake_traverse_supervisor #(.TICK_CYCLES(10)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .runCmdPin(runCmdPin),
		.proxBreakPin(proxBreakPin), .traverseSensePin(traverseSensePin),
		.brakeResetPin(brakeResetPin), .faultResetPin(faultResetPin),
		.internalBreak(internalBreak), .outFreq(outFreq),
		.feedforwardGain(feedforwardGain), .runEnable(runEnable),
		.coastStop(coastStop), .freqOverride(freqOverride),
		.overrideFreq(overrideFreq), .overrideReverse(overrideReverse),
		.reverseLimitOn(reverseLimitOn),
		.reverseLimitFreq(reverseLimitFreq),
		.breakSignalOut(breakSignalOut), .faultOut(faultOut),
		.brakeOut(brakeOut), .traverseFault(traverseFault),
		.faultCode(faultCode));
	motor_model motor (.ref_clk(ref_clk), .rst_n(rst_n),
		.runEnable(runEnable), .coastStop(coastStop),
		.freqOverride(freqOverride), .overrideFreq(overrideFreq),
		.demandFreq(demandFreq), .outFreq(outFreq));
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			failures++;
			summarize();
		end
	endtask
	task automatic clearFault();
		runCmdPin <= 1'b0;
		proxBreakPin <= 1'b0;
		internalBreak <= 1'b0;
		traverseSensePin <= 1'b0;
		demandFreq <= 16'h0000;
		faultResetPin <= 1'b1;
		repeat (10) @(posedge ref_clk);
		faultResetPin <= 1'b0;
		repeat (110) @(posedge ref_clk);
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			`CHK(rd, {16'h0000, dflt[i]})
		end
		apb(1'b0, 8'h34, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		apb(1'b0, `OFS_GAIN, 32'h0);
		`CHK(rd, 32'hFFFFEC78)
		apb(1'b1, `OFS_DELAY, 32'h2);
		apb(1'b1, `OFS_FILTER, 32'h1);
		apb(1'b1, `OFS_CRTIME, 32'h5);
		apb(1'b1, `OFS_BRHOLD, 32'h3);
		apb(1'b1, `OFS_TRACT, 32'h2);
		apb(1'b1, `OFS_TRINACT, 32'h3);
		// Every reaction code; the last one judged by the drive itself
		for (int r = 0; r < 3; r++) begin
			apb(1'b1, `OFS_CTRL, (32'(r) << 2) | (r == 2 ? 32'h2 : 32'h3)
				| (r == 1 ? 32'h60 : 32'h0));
			runCmdPin <= 1'b1;
			demandFreq <= 16'h03E8;
			repeat (60) @(posedge ref_clk);
			if (r == 2)
				internalBreak <= 1'b1;
			else
				proxBreakPin <= 1'b1;
			`WAITC(faultOut)
			`CHK(k >= 90 && k <= 130, 1'b1)
			`CHK(freqOverride, r < 2)
			if (r < 2)
				`CHK(overrideFreq, `CRFREQ_RST)
			`CHK(overrideReverse, r == 1)
			`CHK(reverseLimitOn, r == 1)
			`CHK(reverseLimitFreq, r == 1 ? `CRFREQ_RST : 16'h0)
			if (r == 1) begin
				`WAITC(!freqOverride)
				`CHK(k >= 40 && k <= 65, 1'b1)
				`CHK({faultOut, runEnable}, 2'b10)
			end
			if (r == 0) begin
				repeat (100) @(posedge ref_clk);
				`CHK(freqOverride, 1'b1)
			end
			clearFault();
			`CHK(faultOut, 1'b0)
		end
		// Brake fires only with mode and output function both set
		for (int b = 0; b < 3; b++) begin
			apb(1'b1, `OFS_CTRL, brk[b]);
			runCmdPin <= 1'b1;
			demandFreq <= 16'h03E8;
			`WAITC(outFreq == 16'h03E8)
			runCmdPin <= 1'b0;
			demandFreq <= 16'h0000;
			`WAITC(brakeOut || outFreq == 16'h0000)
			`CHK(brakeOut, b == 0)
			if (b == 0) begin
				`CHK(outFreq <= 16'h00FA && outFreq >= 16'h0050, 1'b1)
				runCmdPin <= 1'b1;
				`WAITC(!brakeOut)
				`CHK(k >= 20 && k <= 40, 1'b1)
				`CHK(runEnable, 1'b0)
			end
			clearFault();
		end
		// Zero hold time: brake stays until the brake reset pin
		apb(1'b1, `OFS_BRHOLD, 32'h0);
		apb(1'b1, `OFS_CTRL, 32'h090);
		runCmdPin <= 1'b1;
		demandFreq <= 16'h03E8;
		`WAITC(outFreq == 16'h03E8)
		runCmdPin <= 1'b0;
		demandFreq <= 16'h0000;
		`WAITC(brakeOut)
		repeat (100) @(posedge ref_clk);
		`CHK(brakeOut, 1'b1)
		brakeResetPin <= 1'b1;
		`WAITC(!brakeOut)
		`CHK(k >= 4 && k <= 8, 1'b1)
		brakeResetPin <= 1'b0;
		clearFault();
		// Stuck-active then stuck-inactive traverse input
		for (int s = 1; s >= 0; s--) begin
			apb(1'b1, `OFS_CTRL, 32'h100);
			traverseSensePin <= 1'(s);
			runCmdPin <= 1'b1;
			demandFreq <= 16'h04B0;
			`WAITC(outFreq >= `TRMIN_RST)
			`WAITC(traverseFault)
			`CHK(k >= 10 * (3 - s) - 10 && k <= 10 * (3 - s) + 20, 1'b1)
			`CHK(faultCode, `TRAV_FAULT_CODE)
			runCmdPin <= 1'b0;
			apb(1'b1, `OFS_CTRL, 32'h300);
			repeat (2) @(posedge ref_clk);
			`CHK(traverseFault, 1'b0)
			clearFault();
		end
		summarize();
	end
endmodule // tb_top
`default_nettype wire

// file: verilog/wire_break_brake_traverse_supervisor.v
`timescale 1ns/1ps
`default_nettype none
`include "wire_break_map.vh"
module wire_break_brake_traverse_supervisor #(
	parameter TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Terminal pins
	input wire runCmdPin,
	input wire proxBreakPin,
	input wire traverseSensePin,
	input wire brakeResetPin,
	input wire faultResetPin,
	// Drive-side values, same clock
	input wire internalBreak,
	input wire [15:0] outFreq,
	input wire signed [15:0] feedforwardGain,
	// Drive outputs
	output reg runEnable,
	output reg coastStop,
	output reg freqOverride,
	output reg [15:0] overrideFreq,
	output reg overrideReverse,
	output reg reverseLimitOn,
	output reg [15:0] reverseLimitFreq,
	output reg breakSignalOut,
	output reg faultOut,
	output reg brakeOut,
	output reg traverseFault,
	output reg [7:0] faultCode
);

localparam ST_IDLE = 2'h0;
localparam ST_CONT = 2'h1;
localparam ST_TIMED = 2'h2;
localparam ST_FAULT = 2'h3;
localparam NPIN = 5;

// Pin synchronisers: change accepted once stages two and three agree
reg [NPIN-1:0] syncA, syncB, syncC, pinState;
wire [NPIN-1:0] pinRaw = {faultResetPin, brakeResetPin, traverseSensePin,
	proxBreakPin, runCmdPin};
genvar gi;
generate
	for (gi = 0; gi < NPIN; gi = gi + 1) begin : gSync
		always @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				syncA[gi] <= 1'b0;
				syncB[gi] <= 1'b0;
				syncC[gi] <= 1'b0;
				pinState[gi] <= 1'b0;
			end else begin
				syncA[gi] <= pinRaw[gi];
				syncB[gi] <= syncA[gi];
				syncC[gi] <= syncB[gi];
				if (syncB[gi] == syncC[gi])
					pinState[gi] <= syncC[gi];
			end
		end
	end
endgenerate
wire runIn = pinState[0];
wire proxIn = pinState[1];
wire travIn = pinState[2];
wire brakeRst = pinState[3];
wire faultRst = pinState[4];

// Registers
reg [`CTRL_W-1:0] ctrl;
reg [15:0] delayT, floorF, crTime, crFreq, brFreq, brHold;
reg [15:0] trMin, trInact, trAct, filterT;
wire srst = ctrl[`CB_SRST];
wire [1:0] react = ctrl[`CB_REACT_HI:`CB_REACT_LO];

// APB: one wait state, every access answers on the second access cycle
wire apbAcc = psel & penable;
wire apbDone = apbAcc & pready;
reg mapped;
reg [31:0] rdMux;
reg [1:0] bstate;
reg floorArmed, armed, stopSuppress;
reg [31:0] statusWord;
always @* begin
	mapped = 1'b1;
	rdMux = 32'h0;
	case (paddr)
	`OFS_CTRL: rdMux = {{(32-`CTRL_W){1'b0}}, ctrl};
	`OFS_DELAY: rdMux = {16'h0, delayT};
	`OFS_FLOOR: rdMux = {16'h0, floorF};
	`OFS_CRTIME: rdMux = {16'h0, crTime};
	`OFS_CRFREQ: rdMux = {16'h0, crFreq};
	`OFS_BRFREQ: rdMux = {16'h0, brFreq};
	`OFS_BRHOLD: rdMux = {16'h0, brHold};
	`OFS_TRMIN: rdMux = {16'h0, trMin};
	`OFS_TRINACT: rdMux = {16'h0, trInact};
	`OFS_TRACT: rdMux = {16'h0, trAct};
	`OFS_FILTER: rdMux = {16'h0, filterT};
	`OFS_STATUS: rdMux = statusWord;
	`OFS_GAIN: rdMux = {{16{feedforwardGain[15]}}, feedforwardGain};
	default: mapped = 1'b0;
	endcase
end

always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h0;
	end else begin
		pready <= apbAcc & ~pready;
		pslverr <= apbAcc & ~pready & ~mapped;
		prdata <= (apbAcc & ~pready & ~pwrite) ? rdMux : 32'h0;
	end
end

always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		ctrl <= `CTRL_RST;
		delayT <= `DELAY_RST;
		floorF <= `FLOOR_RST;
		crTime <= `CRTIME_RST;
		crFreq <= `CRFREQ_RST;
		brFreq <= `BRFREQ_RST;
		brHold <= `BRHOLD_RST;
		trMin <= `TRMIN_RST;
		trInact <= `TRINACT_RST;
		trAct <= `TRACT_RST;
		filterT <= `FILTER_RST;
	end else if (apbDone & pwrite) begin
		case (paddr)
		`OFS_CTRL: ctrl <= pwdata[`CTRL_W-1:0];
		`OFS_DELAY: delayT <= pwdata[15:0];
		`OFS_FLOOR: floorF <= pwdata[15:0];
		`OFS_CRTIME: crTime <= pwdata[15:0];
		`OFS_CRFREQ: crFreq <= pwdata[15:0];
		`OFS_BRFREQ: brFreq <= pwdata[15:0];
		`OFS_BRHOLD: brHold <= pwdata[15:0];
		`OFS_TRMIN: trMin <= pwdata[15:0];
		`OFS_TRINACT: trInact <= pwdata[15:0];
		`OFS_TRACT: trAct <= pwdata[15:0];
		`OFS_FILTER: filterT <= pwdata[15:0];
		default: ;
		endcase
	end
end
// 0.1 s time base
reg [31:0] tickCnt;
reg tick;
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		tickCnt <= 32'h0;
		tick <= 1'b0;
	end else if (srst || tickCnt == TICK_CYCLES - 1) begin
		tickCnt <= 32'h0;
		tick <= ~srst;
	end else begin
		tickCnt <= tickCnt + 32'h1;
		tick <= 1'b0;
	end
end

// Run acceptance and break-detection gating
reg running, runPrev;
reg [15:0] delayCnt, filterCnt, crCnt;
reg [15:0] prevFreq;
wire stopping = ~runIn & running;
wire breakRaw = ctrl[`CB_MODE] ? proxIn : internalBreak;
wire [15:0] filterTicks = filterT * `TICKS_PER_S;
always @* begin
	stopSuppress = 1'b0;
	if (stopping) begin
		if (ctrl[`CB_DETCTL])
			stopSuppress = 1'b1;
		else if (floorArmed && outFreq < floorF)
			stopSuppress = 1'b1;
	end
end
wire detectOn = running & armed & ~stopSuppress & bstate == ST_IDLE;
wire judged = detectOn & breakRaw & tick & filterCnt + 16'h1 >= filterTicks;

always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		running <= 1'b0;
		runPrev <= 1'b0;
		delayCnt <= 16'h0;
		armed <= 1'b0;
		floorArmed <= 1'b0;
		filterCnt <= 16'h0;
	end else if (srst) begin
		running <= 1'b0;
		runPrev <= 1'b0;
		delayCnt <= 16'h0;
		armed <= 1'b0;
		floorArmed <= 1'b0;
		filterCnt <= 16'h0;
	end else begin
		runPrev <= runIn;
		// Stale commands during the brake are dropped, not queued
		if (runIn & ~runPrev & ~brakeOut & bstate == ST_IDLE & ~traverseFault)
			running <= 1'b1;
		else if (outFreq == 16'h0 & ~runIn || brakeOut || coastStop)
			running <= 1'b0;
		if (~running) begin
			delayCnt <= 16'h0;
			armed <= 1'b0;
			floorArmed <= 1'b0;
		end else begin
			if (delayCnt >= delayT)
				armed <= 1'b1;
			else if (tick)
				delayCnt <= delayCnt + 16'h1;
			if (outFreq > floorF)
				floorArmed <= 1'b1;
		end
		if (~detectOn | ~breakRaw)
			filterCnt <= 16'h0;
		else if (tick & filterCnt < filterTicks)
			filterCnt <= filterCnt + 16'h1;
	end
end
// Break reaction
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		bstate <= ST_IDLE;
		crCnt <= 16'h0;
	end else if (srst) begin
		bstate <= ST_IDLE;
		crCnt <= 16'h0;
	end else begin
		case (bstate)
		ST_IDLE: begin
			crCnt <= 16'h0;
			if (judged) begin
				case (react)
				`REACT_CONT: bstate <= ST_CONT;
				`REACT_TIMED: bstate <= ST_TIMED;
				default: bstate <= ST_FAULT;
				endcase
			end
		end
		ST_CONT: if (faultRst) bstate <= ST_IDLE;
		ST_TIMED: begin
			if (faultRst)
				bstate <= ST_IDLE;
			else if (crCnt >= crTime)
				bstate <= ST_FAULT;
			else if (tick)
				crCnt <= crCnt + 16'h1;
		end
		ST_FAULT: if (faultRst) bstate <= ST_IDLE;
		default: bstate <= ST_IDLE;
		endcase
	end
end
// Brake control
reg [15:0] holdCnt;
wire brakeOn = ctrl[`CB_BRMODE] & ctrl[`CB_BRFUNC];
wire crossDown = tick & prevFreq > brFreq & outFreq <= brFreq;
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		prevFreq <= 16'h0;
		brakeOut <= 1'b0;
		holdCnt <= 16'h0;
	end else if (srst) begin
		prevFreq <= 16'h0;
		brakeOut <= 1'b0;
		holdCnt <= 16'h0;
	end else begin
		if (tick)
			prevFreq <= outFreq;
		if (~brakeOut) begin
			holdCnt <= 16'h0;
			if (brakeOn & crossDown)
				brakeOut <= 1'b1;
		end else if (brHold == 16'h0) begin
			if (brakeRst | faultRst)
				brakeOut <= 1'b0;
		end else if (holdCnt >= brHold) begin
			brakeOut <= 1'b0;
		end else if (tick) begin
			holdCnt <= holdCnt + 16'h1;
		end
	end
end
// Traverse supervision
reg [15:0] inactCnt, actCnt;
reg travArmed;
wire travOn = ctrl[`CB_TRFUNC] & running;
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		travArmed <= 1'b0;
		inactCnt <= 16'h0;
		actCnt <= 16'h0;
		traverseFault <= 1'b0;
		faultCode <= 8'h0;
	end else if (srst) begin
		travArmed <= 1'b0;
		inactCnt <= 16'h0;
		actCnt <= 16'h0;
		traverseFault <= 1'b0;
		faultCode <= 8'h0;
	end else begin
		if (~travOn)
			travArmed <= 1'b0;
		else if (outFreq >= trMin)
			travArmed <= 1'b1;
		if (~travArmed | travIn)
			inactCnt <= 16'h0;
		else if (tick)
			inactCnt <= inactCnt + 16'h1;
		if (~travArmed | ~travIn)
			actCnt <= 16'h0;
		else if (tick)
			actCnt <= actCnt + 16'h1;
		// Fault set wins over a reset arriving the same cycle
		if (travArmed & (inactCnt >= trInact | actCnt >= trAct)) begin
			traverseFault <= 1'b1;
			faultCode <= `TRAV_FAULT_CODE;
		end else if (faultRst) begin
			traverseFault <= 1'b0;
			faultCode <= 8'h0;
		end
	end
end
// Drive-facing outputs, all registered; soft reset drops them at once
wire inBreakRun = ~srst & (bstate == ST_CONT | bstate == ST_TIMED);
wire liveRun = ~srst & ~brakeOut & ~traverseFault & bstate != ST_FAULT;
always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n) begin
		runEnable <= 1'b0;
		coastStop <= 1'b0;
		freqOverride <= 1'b0;
		overrideFreq <= 16'h0;
		overrideReverse <= 1'b0;
		reverseLimitOn <= 1'b0;
		reverseLimitFreq <= 16'h0;
		breakSignalOut <= 1'b0;
		faultOut <= 1'b0;
	end else begin
		runEnable <= (running | inBreakRun) & liveRun;
		coastStop <= ~srst & (brakeOut | traverseFault);
		freqOverride <= inBreakRun;
		overrideFreq <= inBreakRun ? crFreq : 16'h0;
		overrideReverse <= inBreakRun & ctrl[`CB_UNWIND];
		reverseLimitOn <= ~srst & ctrl[`CB_UNWREV];
		reverseLimitFreq <= (~srst & ctrl[`CB_UNWREV]) ? crFreq : 16'h0;
		breakSignalOut <= inBreakRun;
		faultOut <= ~srst & (bstate != ST_IDLE | traverseFault);
	end
end
always @*
	statusWord = {filterCnt, faultCode, travArmed, traverseFault, brakeOut,
		floorArmed, armed, running, bstate};

endmodule // wire_break_brake_traverse_supervisor
`default_nettype wire

// file: verilog/wire_break_map.vh
// Contract
// - Detection-mode digit picks internal judgement (0) or proximity switch (1).
// - Control digit 0: no detection while stopping below the stop floor.
// - Control digit 1: never detect breaks while stopping.
// - Reaction 0: keep running at continue-run frequency, raise break and fault.
// - Reaction 1: raise outputs, run continue-run time, then stop into fault.
// - Reaction 2: enter fault at once when a break is judged.
// - Brake mode 1 fires brake on downward crossing of brake frequency.
// - Unwind-reverse digit 1 clamps reverse speed to continue-run frequency.
// - Hold off break detection for the detection delay after run accepted.
// - Stop floor applies only after frequency once exceeded it then fell.
// - Continue-run timer starts at judgement; direction reverse unwinding, forward winding.
// - Brake settings act only when brake-control output function is assigned.
// - Brake asserted at crossing, held, released after brake duration.
// - While brake is asserted, remove drive and coast.
// - Run commands ignored while brake output is asserted.
// - Brake duration zero: brake held until brake or fault reset.
// - Traverse check only with its input function, above traverse minimum frequency; code keeps checking below it once reached, while running.
// - Traverse input inactive for inactive time: traverse switch failure.
// - Traverse input active for active time: traverse arm stopped.
// - Traverse fault reports traverse fault code and coasts the motor.
// - Break indication must persist for the filter time before acceptance.
// - Present feedforward gain readable, -500.0 to 500.0 percent.
`ifndef WIRE_BREAK_MAP_VH
`define WIRE_BREAK_MAP_VH
`define CLK_PERIOD_NS 40
`define TICK_TIME_NS 100000000
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_DELAY 8'h04
`define OFS_FLOOR 8'h08
`define OFS_CRTIME 8'h0C
`define OFS_CRFREQ 8'h10
`define OFS_BRFREQ 8'h14
`define OFS_BRHOLD 8'h18
`define OFS_TRMIN 8'h1C
`define OFS_TRINACT 8'h20
`define OFS_TRACT 8'h24
`define OFS_FILTER 8'h28
`define OFS_STATUS 8'h2C
`define OFS_GAIN 8'h30
// Control word fields
`define CB_MODE 0
`define CB_DETCTL 1
`define CB_REACT_LO 2
`define CB_REACT_HI 3
`define CB_BRMODE 4
`define CB_UNWREV 5
`define CB_UNWIND 6
`define CB_BRFUNC 7
`define CB_TRFUNC 8
`define CB_SRST 9
`define CTRL_W 10
`define CTRL_RST 10'h0BB
// Reaction codes
`define REACT_CONT 2'h0
`define REACT_TIMED 2'h1
`define REACT_FAULT 2'h2
// Defaults: tenths of s, hundredths of Hz, whole s for the filter
`define DELAY_RST 16'h003C
`define FLOOR_RST 16'h01F4
`define CRTIME_RST 16'h0064
`define CRFREQ_RST 16'h01F4
`define BRFREQ_RST 16'h00FA
`define BRHOLD_RST 16'h0032
`define TRMIN_RST 16'h03E8
`define TRINACT_RST 16'h0064
`define TRACT_RST 16'h0014
`define FILTER_RST 16'h0005
`define TICKS_PER_S 16'h000A
`define TRAV_FAULT_CODE 8'h2C
`endif
